// ---- plg_gating_unit.sv ----
/*
  Programmable-logic gating unit: bit and word forms of OR NOT,
  exclusive gate and equivalence gate, plain and inverted load,
  addition and assignment, acting on a one-bit logic accumulator
  and a 32-bit word accumulator.
  Assumes the instruction sequencer presents one command per cycle
  with cmd_valid_i, and the operand store has the operand ready in
  the same cycle. Results appear one cycle after acceptance.
*/
module plg_gating_unit
  import plg_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              reset_n_i,
  input  wire logic              cmd_valid_i,
  input  wire plg_pkg::plg_cmd_t cmd_op_i,
  input  wire plg_pkg::plg_cls_t cmd_cls_i,
  input  wire logic              opnd_bit_i,
  input  wire logic [31:0]       opnd_word_i,
  output logic                   cmd_ready_o,
  output logic                   done_o,
  output logic                   bad_operand_o,
  output logic                   logic_acc_o,
  output logic [31:0]            word_acc_o,
  output logic                   seq_open_o,
  output logic                   store_valid_o,
  output logic                   store_bit_o,
  output logic [31:0]            store_word_o
);
  import plg_pkg::*;

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  logic        logic_acc_q;
  logic        logic_acc_d;
  logic [31:0] word_acc_q;
  logic [31:0] word_acc_d;
  plg_seq_t    seq_q;
  plg_seq_t    seq_d;
  logic        done_q;
  logic        bad_q;
  logic        bad_d;
  logic        store_valid_q;
  logic        store_bit_q;
  logic [31:0] store_word_q;

  // -----------------------------------------------------------------
  // operand fitting
  // -----------------------------------------------------------------
  logic        opnd_is_bit;
  logic        opnd_is_word;
  logic [31:0] opnd_mask;
  logic [31:0] opnd_wide;

  plg_operand_fit u_fit (
    .cls_i     (cmd_cls_i),
    .raw_i     (opnd_word_i),
    .is_bit_o  (opnd_is_bit),
    .is_word_o (opnd_is_word),
    .mask_o    (opnd_mask),
    .wide_o    (opnd_wide)
  );

  // -----------------------------------------------------------------
  // command classification
  // -----------------------------------------------------------------
  logic is_gate_cmd;
  logic is_load_cmd;
  logic is_bit_form;
  logic is_word_form;
  logic in_seq;

  assign in_seq = (seq_q == PLG_SEQ_OPEN);

  always_comb begin
    is_gate_cmd = 1'b0;
    is_load_cmd = 1'b0;
    case (cmd_op_i)
      PLG_OR_NOT_CMD,
      PLG_EXCLUSIVE_GATE_CMD,
      PLG_EQUIVALENCE_GATE_CMD: begin
        is_gate_cmd = 1'b1;
      end
      PLG_LOAD,
      PLG_INVERTED_LOAD_CMD: begin
        is_load_cmd = 1'b1;
      end
      default: begin
        is_gate_cmd = 1'b0;
        is_load_cmd = 1'b0;
      end
    endcase
  end

  assign is_bit_form  = (is_gate_cmd | is_load_cmd) & opnd_is_bit;
  assign is_word_form = (is_gate_cmd | is_load_cmd) & opnd_is_word;

  // -----------------------------------------------------------------
  // bit-form result
  // -----------------------------------------------------------------
  logic bit_result;

  always_comb begin
    bit_result = logic_acc_q;
    case (cmd_op_i)
      PLG_LOAD: begin
        bit_result = opnd_bit_i;
      end
      PLG_INVERTED_LOAD_CMD: begin
        bit_result = ~opnd_bit_i;
      end
      PLG_OR_NOT_CMD: begin
        if (in_seq) begin
          bit_result = logic_acc_q | ~opnd_bit_i; // RULE2
        end else begin
          bit_result = ~opnd_bit_i; // RULE1
        end
      end
      PLG_EXCLUSIVE_GATE_CMD: begin
        if (in_seq) begin
          bit_result = logic_acc_q ^ opnd_bit_i; // RULE8
        end else begin
          bit_result = opnd_bit_i; // RULE7
        end
      end
      PLG_EQUIVALENCE_GATE_CMD: begin
        if (in_seq) begin
          bit_result = ~(logic_acc_q ^ opnd_bit_i); // RULE11
        end else begin
          bit_result = ~opnd_bit_i; // RULE10
        end
      end
      default: begin
        bit_result = logic_acc_q;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // word-form gating, one cell per accumulator bit
  // -----------------------------------------------------------------
  plg_gate_t   gate_sel;
  logic [31:0] gated_word;

  always_comb begin
    case (cmd_op_i)
      PLG_OR_NOT_CMD: begin
        gate_sel = PLG_GATE_OR_NOT;
      end
      PLG_EXCLUSIVE_GATE_CMD: begin
        gate_sel = PLG_GATE_XOR;
      end
      PLG_EQUIVALENCE_GATE_CMD: begin
        gate_sel = PLG_GATE_XNOR;
      end
      default: begin
        gate_sel = PLG_GATE_PASS;
      end
    endcase
  end

  for (genvar n = 0; n < ACC_W; n++) begin : g_cell
    logic a;
    logic b;
    logic f;
    assign a = word_acc_q[n];
    assign b = opnd_word_i[n]; // RULE5
    always_comb begin
      case (gate_sel)
        PLG_GATE_OR_NOT: begin
          f = a | ~b; // RULE6
        end
        PLG_GATE_XOR: begin
          f = a ^ b; // RULE9
        end
        PLG_GATE_XNOR: begin
          f = ~(a ^ b); // RULE12
        end
        default: begin
          f = a;
        end
      endcase
    end
    assign gated_word[n] = opnd_mask[n] ? f : a; // RULE4
  end

  // -----------------------------------------------------------------
  // next-state decision
  // -----------------------------------------------------------------
  logic [31:0] sum_word;

  // carry dropped on purpose: sum wraps modulo 2^32
  assign sum_word = 32'(word_acc_q + opnd_wide); // RULE13

  // refused commands leave both accumulators untouched
  always_comb begin
    logic_acc_d = logic_acc_q;
    word_acc_d  = word_acc_q;
    seq_d       = seq_q;
    bad_d       = 1'b0;
    if (cmd_valid_i) begin
      case (cmd_op_i)
        PLG_LOAD, PLG_INVERTED_LOAD_CMD, PLG_OR_NOT_CMD,
        PLG_EXCLUSIVE_GATE_CMD, PLG_EQUIVALENCE_GATE_CMD: begin
          if (is_bit_form) begin
            logic_acc_d = bit_result;
            seq_d       = PLG_SEQ_OPEN; // RULE16
          end else if (is_word_form && is_load_cmd) begin
            word_acc_d = (cmd_op_i == PLG_LOAD) ? opnd_wide
                                                : ~opnd_wide;
          end else if (is_word_form) begin
            word_acc_d = gated_word;
          end else begin
            bad_d = 1'b1; // RULE3
          end
        end
        PLG_ADD_CMD: begin
          if (opnd_is_word) begin
            word_acc_d = sum_word; // RULE14
          end else begin
            bad_d = 1'b1;
          end
        end
        PLG_ASSIGN_CMD: begin
          seq_d = PLG_SEQ_CLOSED; // RULE16
        end
        PLG_NOP_CMD: begin
          seq_d = seq_q;
        end
        default: begin
          bad_d = 1'b1;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // accumulators
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      logic_acc_q <= LOGIC_RST;
      word_acc_q  <= WORD_RST;
    end else begin
      logic_acc_q <= logic_acc_d;
      word_acc_q  <= word_acc_d;
    end
  end

  // -----------------------------------------------------------------
  // logic sequence tracking
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      seq_q <= PLG_SEQ_CLOSED; // RULE16
    end else begin
      seq_q <= seq_d;
    end
  end

  // -----------------------------------------------------------------
  // completion and error pulses
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_q <= 1'b0;
      bad_q  <= 1'b0;
    end else begin
      done_q <= cmd_valid_i;
      bad_q  <= bad_d;
    end
  end

  // -----------------------------------------------------------------
  // assignment port toward the operand store
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      store_valid_q <= 1'b0;
      store_bit_q   <= LOGIC_RST;
      store_word_q  <= WORD_RST;
    end else begin
      store_valid_q <= cmd_valid_i && (cmd_op_i == PLG_ASSIGN_CMD);
      if (cmd_valid_i && (cmd_op_i == PLG_ASSIGN_CMD)) begin
        store_bit_q  <= logic_acc_q;
        store_word_q <= word_acc_q & opnd_mask;
      end
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  // one command per cycle, never stalls
  assign cmd_ready_o   = 1'b1;
  assign done_o        = done_q;
  assign bad_operand_o = bad_q;
  assign logic_acc_o   = logic_acc_q;
  assign word_acc_o    = word_acc_q;
  assign seq_open_o    = (seq_q == PLG_SEQ_OPEN);
  assign store_valid_o = store_valid_q;
  assign store_bit_o   = store_bit_q;
  assign store_word_o  = store_word_q;

endmodule // plg_gating_unit

// ---- plg_pkg.sv ----
/*
  Shared constants and types of the programmable-logic gating unit:
  command and operand class encodings, accumulator widths, reset values,
  sequence states and the widening modes of the operand fitter.
  Assumes one processing clock and an instruction sequencer that
  presents one command per cycle with a valid strobe.
*/
// Function
// [RULE1] opening OR NOT loads inverted operand bit
// [RULE2] open-sequence OR NOT: acc or not operand
// [RULE3] bit form takes marker/input/output/timer/counter
// [RULE4] word form touches only operand-width low bits; word loads write all 32 bits of the sign-widened operand
// [RULE5] word gating pairs bit n with n
// [RULE6] word OR NOT result kept in accumulator
// [RULE7] opening exclusive gate loads operand bit
// [RULE8] open-sequence exclusive gate: acc xor operand
// [RULE9] word exclusive gate kept in accumulator
// [RULE10] opening equivalence gate acts as inverted load
// [RULE11] open-sequence equivalence gate: acc xnor operand
// [RULE12] word equivalence gate kept in accumulator
// [RULE13] add widens operand to 32 bits first
// [RULE14] add writes sum back to word accumulator
// [RULE15] program should open chains with load
// [RULE16] track open sequence; assign/reset closes it
package plg_pkg;

  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int unsigned ACC_W      = 32;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned DWORD_W    = 32;
  localparam logic        LOGIC_RST  = 1'b0;
  localparam logic [31:0] WORD_RST   = 32'h0000_0000;
  localparam logic [31:0] MASK_BYTE  = 32'h0000_00FF;
  localparam logic [31:0] MASK_WORD  = 32'h0000_FFFF;
  localparam logic [31:0] MASK_DWORD = 32'hFFFF_FFFF;

  // ---------------------------------------------------------------
  // commands from the sequencer
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    PLG_LOAD              = 4'h0,
    PLG_INVERTED_LOAD_CMD = 4'h1,
    PLG_OR_NOT_CMD        = 4'h2,
    PLG_EXCLUSIVE_GATE_CMD   = 4'h3,
    PLG_EQUIVALENCE_GATE_CMD = 4'h4,
    PLG_ADD_CMD           = 4'h5,
    PLG_ASSIGN_CMD        = 4'h6,
    PLG_NOP_CMD           = 4'h7
  } plg_cmd_t;

  // ---------------------------------------------------------------
  // operand classes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    PLG_CLS_MARKER  = 4'h0,
    PLG_CLS_INPUT   = 4'h1,
    PLG_CLS_OUTPUT  = 4'h2,
    PLG_CLS_TIMER   = 4'h3,
    PLG_CLS_COUNTER = 4'h4,
    PLG_CLS_BYTE    = 4'h5,
    PLG_CLS_WORD    = 4'h6,
    PLG_CLS_DWORD   = 4'h7,
    PLG_CLS_CONST   = 4'h8
  } plg_cls_t;

  // ---------------------------------------------------------------
  // logic sequence state, gray along closed -> open -> closed
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PLG_SEQ_CLOSED = 2'b00,
    PLG_SEQ_OPEN   = 2'b01
  } plg_seq_t;

  // ---------------------------------------------------------------
  // per-bit word gate selections
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PLG_GATE_OR_NOT = 2'b00,
    PLG_GATE_XOR    = 2'b01,
    PLG_GATE_XNOR   = 2'b11,
    PLG_GATE_PASS   = 2'b10
  } plg_gate_t;

endpackage

// ---- plg_operand_fit.sv ----
/*
  Operand fitter: derives the influenced-bit mask of a word operand
  and its sign-widened 32-bit value, and tells bit-class from
  word-class operands. Purely combinational.
  Assumes the operand store delivers narrow operands in the low bits.
*/
module plg_operand_fit
  import plg_pkg::*;
(
  input  wire plg_pkg::plg_cls_t cls_i,
  input  wire logic [31:0]       raw_i,
  output logic                   is_bit_o,
  output logic                   is_word_o,
  output logic [31:0]            mask_o,
  output logic [31:0]            wide_o
);

  // -----------------------------------------------------------------
  // class decode and widening
  // -----------------------------------------------------------------
  always_comb begin
    is_bit_o  = 1'b0;
    is_word_o = 1'b0;
    mask_o    = MASK_DWORD;
    wide_o    = raw_i;
    case (cls_i)
      PLG_CLS_MARKER, PLG_CLS_INPUT, PLG_CLS_OUTPUT,
      PLG_CLS_TIMER, PLG_CLS_COUNTER: begin
        is_bit_o = 1'b1; // RULE3
      end
      PLG_CLS_BYTE: begin
        is_word_o = 1'b1;
        mask_o    = MASK_BYTE; // RULE4
        wide_o    = {{(ACC_W-BYTE_W){raw_i[BYTE_W-1]}},
                     raw_i[BYTE_W-1:0]}; // RULE13
      end
      PLG_CLS_WORD: begin
        is_word_o = 1'b1;
        mask_o    = MASK_WORD; // RULE4
        wide_o    = {{(ACC_W-WORD_W){raw_i[WORD_W-1]}},
                     raw_i[WORD_W-1:0]}; // RULE13
      end
      PLG_CLS_DWORD, PLG_CLS_CONST: begin
        is_word_o = 1'b1;
        mask_o    = MASK_DWORD; // RULE4
      end
      default: begin
        is_bit_o  = 1'b0;
        is_word_o = 1'b0;
      end
    endcase
  end

endmodule // plg_operand_fit

// ---- plg_gating_asserts.sv ----
/*
  Checker of the gating unit: gate relations, refusal and
  sequence closing, seen at the top module's ports.
  Assumes one clock and an asynchronous active-low reset.
*/
module plg_gating_asserts (
  input wire logic              clk_sys_i,
  input wire logic              reset_n_i,
  input wire logic              cmd_valid_i,
  input wire plg_pkg::plg_cmd_t cmd_op_i,
  input wire plg_pkg::plg_cls_t cmd_cls_i,
  input wire logic              opnd_bit_i,
  input wire logic [31:0]       opnd_word_i,
  input wire logic              cmd_ready_o,
  input wire logic              done_o,
  input wire logic              bad_operand_o,
  input wire logic              logic_acc_o,
  input wire logic [31:0]       word_acc_o,
  input wire logic              seq_open_o,
  input wire logic              store_valid_o,
  input wire logic              store_bit_o,
  input wire logic [31:0]       store_word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import plg_pkg::*;
  // ---------------------------------------------------------------
  // helpers and assertions
  // ---------------------------------------------------------------
  wire        gb = cmd_valid_i && (cmd_cls_i <= PLG_CLS_COUNTER);
  wire [31:0] sw = {{16{opnd_word_i[15]}}, opnd_word_i[15:0]};
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  chk_ornot_open: assert property (
    gb && cmd_op_i == PLG_OR_NOT_CMD && !seq_open_o
    |=> logic_acc_o == !$past(opnd_bit_i) && seq_open_o)
    else $error("or-not open failed");
  chk_ornot_seq: assert property (
    gb && cmd_op_i == PLG_OR_NOT_CMD && seq_open_o
    |=> logic_acc_o == ($past(logic_acc_o) | !$past(opnd_bit_i)))
    else $error("or-not in sequence failed");
  chk_exg_open: assert property (
    gb && cmd_op_i == PLG_EXCLUSIVE_GATE_CMD && !seq_open_o
    |=> logic_acc_o == $past(opnd_bit_i))
    else $error("exclusive gate open failed");
  chk_exg_seq: assert property (
    gb && cmd_op_i == PLG_EXCLUSIVE_GATE_CMD && seq_open_o
    |=> logic_acc_o == ($past(logic_acc_o) ^ $past(opnd_bit_i)))
    else $error("exclusive gate in sequence failed");
  chk_eqv_open: assert property (
    gb && cmd_op_i == PLG_EQUIVALENCE_GATE_CMD && !seq_open_o
    |=> logic_acc_o == !$past(opnd_bit_i))
    else $error("equivalence open failed");
  chk_eqv_seq: assert property (
    gb && cmd_op_i == PLG_EQUIVALENCE_GATE_CMD && seq_open_o
    |=> logic_acc_o == !($past(logic_acc_o) ^ $past(opnd_bit_i)))
    else $error("equivalence in sequence failed");
  chk_bad_class: assert property (
    cmd_valid_i && cmd_cls_i > PLG_CLS_CONST && cmd_op_i inside
    {PLG_OR_NOT_CMD, PLG_EXCLUSIVE_GATE_CMD, PLG_EQUIVALENCE_GATE_CMD}
    |=> bad_operand_o && $stable(logic_acc_o) && $stable(word_acc_o))
    else $error("illegal class not refused");
  chk_byte_exg: assert property (
    cmd_valid_i && cmd_op_i == PLG_EXCLUSIVE_GATE_CMD
    && cmd_cls_i == PLG_CLS_BYTE |=> word_acc_o ==
    ($past(word_acc_o) ^ ($past(opnd_word_i) & MASK_BYTE)))
    else $error("byte exclusive gate failed");
  chk_word_ornot: assert property (
    cmd_valid_i && cmd_op_i == PLG_OR_NOT_CMD && cmd_cls_i == PLG_CLS_WORD
    |=> word_acc_o == ($past(word_acc_o) | (~$past(opnd_word_i) & MASK_WORD)))
    else $error("word or-not failed");
  chk_add_word: assert property (
    cmd_valid_i && cmd_op_i == PLG_ADD_CMD && cmd_cls_i == PLG_CLS_WORD
    |=> word_acc_o == $past(word_acc_o) + $past(sw))
    else $error("word add failed");
  chk_assign_close: assert property (
    cmd_valid_i && cmd_op_i == PLG_ASSIGN_CMD |=> !seq_open_o
    && store_valid_o && store_bit_o == $past(logic_acc_o))
    else $error("assign did not close sequence");
  cov_ornot_seq: cover property (gb && cmd_op_i == PLG_OR_NOT_CMD && seq_open_o);
  cov_refused: cover property (bad_operand_o);
  cov_store: cover property (store_valid_o);
endmodule // plg_gating_asserts
bind plg_gating_unit plg_gating_asserts plg_gating_asserts_inst (.*);

// ---- plg_seq_model.sv ----
/*
  Sequencer and operand store model: presents one command per call
  at the falling edge and inverts stale operands when idle.
  Assumes the caller is at a falling edge of the clock.
*/
module plg_seq_model (
  output logic              cmd_valid_o,
  output plg_pkg::plg_cmd_t cmd_op_o,
  output plg_pkg::plg_cls_t cmd_cls_o,
  output logic              opnd_bit_o,
  output logic [31:0]       opnd_word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import plg_pkg::*;
  initial begin
    cmd_valid_o = 1'h0;
    cmd_op_o    = PLG_NOP_CMD;
    cmd_cls_o   = PLG_CLS_MARKER;
    opnd_bit_o  = 1'h0;
    opnd_word_o = 32'h0;
  end
  task automatic issue(input plg_cmd_t op, input plg_cls_t cls,
                       input logic b, input logic [31:0] w);
    cmd_valid_o = 1'h1;
    cmd_op_o    = op;
    cmd_cls_o   = cls;
    opnd_bit_o  = b;
    opnd_word_o = w;
  endtask
  // stale operand lines shown inverted once released
  task automatic idle();
    cmd_valid_o = 1'h0;
    opnd_bit_o  = ~opnd_bit_o;
    opnd_word_o = ~opnd_word_o;
  endtask
endmodule // plg_seq_model

// ---- plg_gating_unit_tb.sv ----
/*
  Self-checking bench of the gating unit: table of commands with
  expected flags and word accumulator, then refusals and resets.
  Assumes a 250 MHz clock and the sequencer model as driver.
*/
module plg_gating_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import plg_pkg::*;
  // ---------------------------------------------------------------
  // signals, model and design
  // ---------------------------------------------------------------
  typedef struct {
    plg_cmd_t op; plg_cls_t cls; logic b; logic [31:0] w;
    logic [3:0] fl; logic [31:0] wa;
  } plg_row_t;
  localparam plg_cmd_t LD  = PLG_LOAD;
  localparam plg_cmd_t ORN = PLG_OR_NOT_CMD;
  localparam plg_cmd_t EXG = PLG_EXCLUSIVE_GATE_CMD;
  localparam plg_cmd_t EQV = PLG_EQUIVALENCE_GATE_CMD;
  localparam plg_cmd_t ASG = PLG_ASSIGN_CMD;
  localparam plg_cmd_t LDN = PLG_INVERTED_LOAD_CMD;
  localparam plg_cmd_t NOP = PLG_NOP_CMD;
  logic clk_sys_i, reset_n_i, cmd_valid_i, opnd_bit_i;
  logic cmd_ready_o, done_o, bad_operand_o, logic_acc_o, seq_open_o;
  logic store_valid_o, store_bit_o;
  logic [31:0] opnd_word_i, word_acc_o, store_word_o;
  plg_cmd_t cmd_op_i;
  plg_cls_t cmd_cls_i;
  int error_cnt = 0;
  int checked = 0;
  // flags are {done, seq open, logic acc, refused}
  plg_row_t rows [23] = '{
    '{LD,  PLG_CLS_INPUT,   1'h0, 32'h0, 4'hC, 32'h0},
    '{ORN, PLG_CLS_INPUT,   1'h0, 32'h0, 4'hE, 32'h0},
    '{ASG, PLG_CLS_INPUT,   1'h0, 32'h0, 4'hA, 32'h0},
    '{ORN, PLG_CLS_MARKER,  1'h1, 32'h0, 4'hC, 32'h0},
    '{ASG, PLG_CLS_INPUT,   1'h0, 32'h0, 4'h8, 32'h0},
    '{EXG, PLG_CLS_OUTPUT,  1'h1, 32'h0, 4'hE, 32'h0},
    '{EXG, PLG_CLS_TIMER,   1'h1, 32'h0, 4'hC, 32'h0},
    '{ASG, PLG_CLS_INPUT,   1'h0, 32'h0, 4'h8, 32'h0},
    '{EQV, PLG_CLS_COUNTER, 1'h0, 32'h0, 4'hE, 32'h0},
    '{EQV, PLG_CLS_INPUT,   1'h0, 32'h0, 4'hC, 32'h0},
    '{ASG, PLG_CLS_INPUT,   1'h0, 32'h0, 4'h8, 32'h0},
    '{LD,  PLG_CLS_WORD,  1'h0, 32'h3C36, 4'h8, 32'h3C36},
    '{ORN, PLG_CLS_WORD,  1'h0, 32'h36AA, 4'h8, 32'hFD77},
    '{LD,  PLG_CLS_WORD,  1'h0, 32'h3C36, 4'h8, 32'h3C36},
    '{EQV, PLG_CLS_WORD,  1'h0, 32'h36AA, 4'h8, 32'hF563},
    '{LD,  PLG_CLS_BYTE,  1'h0, 32'h36, 4'h8, 32'h36},
    '{EXG, PLG_CLS_BYTE,  1'h0, 32'h2A, 4'h8, 32'h1C},
    '{LD,  PLG_CLS_CONST, 1'h0, 32'hFFFFFFFF, 4'h8, 32'hFFFFFFFF},
    '{EXG, PLG_CLS_BYTE,  1'h0, 32'hFF, 4'h8, 32'hFFFFFF00},
    '{LD,  PLG_CLS_CONST, 1'h0, 32'h2710, 4'h8, 32'h2710},
    '{PLG_ADD_CMD, PLG_CLS_WORD, 1'h0, 32'hC8, 4'h8, 32'h27D8},
    '{PLG_ADD_CMD, PLG_CLS_BYTE, 1'h0, 32'h80, 4'h8, 32'h2758},
    '{EQV, PLG_CLS_DWORD, 1'h0, 32'hFFFF, 4'h8, 32'hFFFF2758}
  };
  plg_seq_model plg_seq_model_inst (
    .cmd_valid_o (cmd_valid_i),
    .cmd_op_o    (cmd_op_i),
    .cmd_cls_o   (cmd_cls_i),
    .opnd_bit_o  (opnd_bit_i),
    .opnd_word_o (opnd_word_i)
  );
  plg_gating_unit plg_gating_unit_inst (.*);
  // ---------------------------------------------------------------
  // tasks and sequence
  // ---------------------------------------------------------------
  initial begin
    clk_sys_i = 1'h0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic step(input plg_row_t r);
    plg_seq_model_inst.issue(r.op, r.cls, r.b, r.w);
    @(negedge clk_sys_i);
    chk(32'({done_o, seq_open_o, logic_acc_o, bad_operand_o}), 32'(r.fl));
    chk(word_acc_o, r.wa);
  endtask
  task automatic do_reset();
    reset_n_i = 1'h0;
    repeat (20) @(negedge clk_sys_i);
    chk(32'({cmd_ready_o, done_o, seq_open_o, logic_acc_o}), 32'h8);
    chk(word_acc_o, 32'h0);
    reset_n_i = 1'h1;
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    error_cnt++;
    close_out();
  end
  initial begin
    do_reset();
    foreach (rows[i]) begin
      step(rows[i]);
    end
    step('{PLG_ADD_CMD, PLG_CLS_INPUT, 1'h1, 32'h5, 4'h9, 32'hFFFF2758});
    step('{EXG, plg_cls_t'(4'h9), 1'h1, 32'h5, 4'h9, 32'hFFFF2758});
    step('{plg_cmd_t'(4'hA), PLG_CLS_INPUT, 1'h1, 32'h5, 4'h9, 32'hFFFF2758});
    step('{LD, PLG_CLS_INPUT, 1'h1, 32'h0, 4'hE, 32'hFFFF2758});
    plg_seq_model_inst.idle();
    do_reset();
    step('{EXG, PLG_CLS_INPUT, 1'h1, 32'h0, 4'hE, 32'h0});
    step('{LD, PLG_CLS_WORD, 1'h0, 32'h8001, 4'hE, 32'hFFFF8001});
    step('{ASG, PLG_CLS_WORD, 1'h0, 32'h0, 4'hA, 32'hFFFF8001});
    chk(32'({store_valid_o, store_bit_o}), 32'h3);
    chk(store_word_o, 32'h8001);
    step('{NOP, PLG_CLS_INPUT, 1'h0, 32'h0, 4'hA, 32'hFFFF8001});
    chk(32'({store_valid_o, store_bit_o}), 32'h1);
    chk(store_word_o, 32'h8001);
    step('{LDN, PLG_CLS_INPUT, 1'h1, 32'h0, 4'hC, 32'hFFFF8001});
    step('{LDN, PLG_CLS_BYTE, 1'h0, 32'h5, 4'hC, 32'hFFFFFFFA});
    plg_seq_model_inst.idle();
    close_out();
  end
endmodule // plg_gating_unit_tb
